// file: shared/pmr_pkg.sv
// constants and types for the power monitor result register block
package pmr_pkg;
  localparam logic [3:0] PMR_ADDR_SETUP = 4'h1;
  localparam logic [3:0] PMR_ADDR_SCALE = 4'h2;
  localparam logic [3:0] PMR_ADDR_SHUNT = 4'h4;
  localparam logic [3:0] PMR_ADDR_RAIL = 4'h5;
  localparam int PMR_SEQ_HI = 15;
  localparam int PMR_SEQ_LO = 12;
  localparam int PMR_AVG_HI = 2;
  localparam int PMR_AVG_LO = 0;
  localparam int PMR_SCALE_HI = 14;
  localparam logic [15:0] PMR_SETUP_RST = 16'hfb68;
  localparam logic [14:0] PMR_SCALE_RST = 15'h1000;
  localparam logic [15:0] PMR_RESULT_RST = 16'h0000;
  localparam logic [2:0] PMR_AVG_RST = 3'h0;
  // seq bit meanings: bit0 rail, bit1 shunt, bit2 temp, bit3 continuous
  localparam int PMR_SEQ_RAIL = 0;
  localparam int PMR_SEQ_SHUNT = 1;
  localparam int PMR_SEQ_CONT = 3;
  typedef enum logic [1:0] {
    PMR_IDLE = 2'b00,
    PMR_ACC = 2'b01,
    PMR_DONE = 2'b10
  } pmr_state_t;
endpackage

// file: verilog/pmr_avg_count.sv
// averaging code to sample count decoder
`timescale 1ns/1ps
`default_nettype none
module pmr_avg_count
  import pmr_pkg::*;
(
  input wire logic [2:0] code,
  output logic [10:0] count
);
  always_comb begin
    case (code)
      3'h0: count = 11'h001;
      3'h1: count = 11'h004;
      3'h2: count = 11'h010;
      3'h3: count = 11'h040;
      3'h4: count = 11'h080;
      3'h5: count = 11'h100;
      3'h6: count = 11'h200;
      default: count = 11'h400;
    endcase
  end
endmodule
`default_nettype wire

// file: verilog/pmr_regs.sv
// power monitor setup, scale and result registers with averaging
`timescale 1ns/1ps
`default_nettype none
module pmr_regs
  import pmr_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic ce,
  input wire logic [3:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  input wire logic input_span_select,
  input wire logic sample_valid,
  input wire logic sample_is_shunt,
  input wire logic signed [15:0] sample_data,
  output logic shunt_active,
  output logic rail_active,
  output logic continuous_mode,
  output logic [14:0] current_scale,
  output logic span_select_out,
  output logic results_updated
);
  logic [15:0] setup_ff;
  logic [14:0] scale_ff;
  logic [15:0] shunt_drop_result_ff;
  logic [15:0] supply_rail_result_ff;
  logic signed [25:0] acc_shunt_ff, acc_rail_ff;
  logic [10:0] cnt_shunt_ff, cnt_rail_ff;
  logic [10:0] avg_target;
  logic [2:0] sample_average_count;
  logic done_shunt, done_rail;
  logic upd_ff;
  logic signed [25:0] sum_shunt, sum_rail;

  assign sample_average_count = setup_ff[PMR_AVG_HI:PMR_AVG_LO];

  pmr_avg_count u_cnt (
    .code(sample_average_count),
    .count(avg_target)
  );

  assign rail_active = setup_ff[PMR_SEQ_LO + PMR_SEQ_RAIL];
  assign shunt_active = setup_ff[PMR_SEQ_LO + PMR_SEQ_SHUNT];
  assign continuous_mode = setup_ff[PMR_SEQ_LO + PMR_SEQ_CONT];
  assign current_scale = scale_ff;
  assign span_select_out = input_span_select;
  assign results_updated = upd_ff;

  always_ff @(posedge mclk) begin
    if (srst) begin
      setup_ff <= PMR_SETUP_RST;
    end else if (ce && reg_wr && reg_addr == PMR_ADDR_SETUP) begin
      setup_ff <= reg_wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      scale_ff <= PMR_SCALE_RST;
    end else if (ce && reg_wr && reg_addr == PMR_ADDR_SCALE) begin
      scale_ff <= reg_wdata[PMR_SCALE_HI:0];
    end
  end

  assign sum_shunt = acc_shunt_ff + 26'(sample_data);
  assign sum_rail = acc_rail_ff + 26'(sample_data);
  // at-or-past target: a count lowered mid-run ends that run on its next sample
  assign done_shunt = sample_valid && sample_is_shunt && shunt_active
                      && (cnt_shunt_ff + 11'h001 >= avg_target);
  assign done_rail = sample_valid && !sample_is_shunt && rail_active
                     && (cnt_rail_ff + 11'h001 >= avg_target);

  // divide by power of two count
  function automatic logic [15:0] avg_div(input logic signed [25:0] s, input logic [2:0] c);
    logic signed [25:0] q;
    q = s;
    case (c)
      3'h0: q = s;
      3'h1: q = s >>> 2;
      3'h2: q = s >>> 4;
      3'h3: q = s >>> 6;
      3'h4: q = s >>> 7;
      3'h5: q = s >>> 8;
      3'h6: q = s >>> 9;
      default: q = s >>> 10;
    endcase
    return q[15:0];
  endfunction

  // accumulators clear on completion, so a new run starts clean
  always_ff @(posedge mclk) begin
    if (srst) begin
      acc_shunt_ff <= '0;
      cnt_shunt_ff <= '0;
    end else if (ce && sample_valid && sample_is_shunt && shunt_active) begin
      acc_shunt_ff <= done_shunt ? '0 : sum_shunt;
      cnt_shunt_ff <= done_shunt ? 11'h000 : cnt_shunt_ff + 11'h001;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      acc_rail_ff <= '0;
      cnt_rail_ff <= '0;
    end else if (ce && sample_valid && !sample_is_shunt && rail_active) begin
      acc_rail_ff <= done_rail ? '0 : sum_rail;
      cnt_rail_ff <= done_rail ? 11'h000 : cnt_rail_ff + 11'h001;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      shunt_drop_result_ff <= PMR_RESULT_RST;
    end else if (ce && done_shunt) begin
      shunt_drop_result_ff <= avg_div(sum_shunt, sample_average_count);
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      supply_rail_result_ff <= PMR_RESULT_RST;
    end else if (ce && done_rail) begin
      supply_rail_result_ff <= sum_rail[25] ? PMR_RESULT_RST
                               : avg_div(sum_rail, sample_average_count);
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      upd_ff <= 1'b0;
    end else if (ce) begin
      upd_ff <= done_shunt || done_rail;
    end
  end

  always_comb begin
    case (reg_addr)
      PMR_ADDR_SETUP: reg_rdata = setup_ff;
      PMR_ADDR_SCALE: reg_rdata = {1'b0, scale_ff};
      PMR_ADDR_SHUNT: reg_rdata = shunt_drop_result_ff;
      PMR_ADDR_RAIL: reg_rdata = supply_rail_result_ff;
      default: reg_rdata = 16'h0000;
    endcase
  end

  property p_scale_msb;
    @(posedge mclk) disable iff (srst) reg_addr == PMR_ADDR_SCALE |-> reg_rdata[15] == 1'b0;
  endproperty
  a_scale_msb: assert property (p_scale_msb) else $error("scale bit 15 not zero");

  property p_ro_write;
    @(posedge mclk) disable iff (srst)
      (ce && reg_wr && reg_addr == PMR_ADDR_SHUNT && !done_shunt)
      |=> $stable(shunt_drop_result_ff);
  endproperty
  a_ro_write: assert property (p_ro_write) else $error("result changed on write");

  property p_upd_only_done;
    @(posedge mclk) disable iff (srst)
      (!$past(done_shunt) && !$past(srst)) |-> $stable(shunt_drop_result_ff);
  endproperty
  a_upd_only_done: assert property (p_upd_only_done) else $error("early update");

  property p_rail_pos;
    @(posedge mclk) disable iff (srst) supply_rail_result_ff[15] == 1'b0;
  endproperty
  a_rail_pos: assert property (p_rail_pos) else $error("rail negative");

  property p_scale_wr;
    @(posedge mclk) disable iff (srst)
      (ce && reg_wr && reg_addr == PMR_ADDR_SCALE) |=> current_scale == $past(reg_wdata[14:0]);
  endproperty
  a_scale_wr: assert property (p_scale_wr) else $error("scale not written");

  property p_count4;
    @(posedge mclk) disable iff (srst) sample_average_count == 3'h1 |-> avg_target == 11'h004;
  endproperty
  a_count4: assert property (p_count4) else $error("bad count");

  sequence s_single_take;
    ce && sample_average_count == 3'h0 && sample_valid && sample_is_shunt && shunt_active;
  endsequence

  sequence s_single_load;
    shunt_drop_result_ff == $past(sample_data);
  endsequence

  property p_single;
    @(posedge mclk) disable iff (srst) s_single_take |=> s_single_load;
  endproperty
  a_single: assert property (p_single) else $error("single sample not stored");

  property p_active;
    @(posedge mclk) disable iff (srst) rail_active == setup_ff[12] && shunt_active == setup_ff[13];
  endproperty
  a_active: assert property (p_active) else $error("active decode wrong");
endmodule
`default_nettype wire

// file: test/pmr_host.sv
// register host model for the block's register port
`timescale 1ns/1ps
`default_nettype none
module pmr_host (
  input wire logic mclk,
  input wire logic [15:0] reg_rdata,
  output logic [3:0] reg_addr,
  output logic reg_wr,
  output logic [15:0] reg_wdata
);
  initial begin
    reg_addr = 4'h0;
    reg_wr = 1'b0;
    reg_wdata = 16'h0000;
  end
  // spare cycle keeps back-to-back writes from retoggling the strobe
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge mclk);
    #1 reg_wr = 1'b0;
    reg_wdata = ~d;
    @(posedge mclk);
    #1;
  endtask
  // sampled mid-cycle, clear of the edge that moves the registers
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    reg_addr = a;
    @(negedge mclk);
    d = reg_rdata;
    @(posedge mclk);
    #1;
  endtask
endmodule
`default_nettype wire

// file: test/test_pmr_regs.sv
// self-checking bench for the result register block
`timescale 1ns/1ps
`default_nettype none
module test_pmr_regs;
  import pmr_pkg::*;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic ce_in = 1'b1;
  logic span = 1'b0;
  logic sv = 1'b0;
  logic sis = 1'b0;
  logic [15:0] sd = 16'h0000;
  logic [3:0] addr;
  logic wr;
  logic [15:0] wdata, rdata, r, d, e;
  logic sh_act, rl_act, cont, span_o, upd;
  logic [14:0] scale;
  logic [3:0] ra [5] = '{4'h1, 4'h2, 4'h4, 4'h5, 4'hf};
  logic [15:0] rv [5] = '{PMR_SETUP_RST, {1'b0, PMR_SCALE_RST}, PMR_RESULT_RST, PMR_RESULT_RST,
    16'h0000};
  int mismatches = 0;
  int checks = 0;
  int cyc = 0;
  always #2.5 mclk = ~mclk;
  pmr_regs dut_u (.mclk(mclk), .srst(srst), .ce(ce_in), .reg_addr(addr), .reg_wr(wr),
    .reg_wdata(wdata), .reg_rdata(rdata), .input_span_select(span), .sample_valid(sv),
    .sample_is_shunt(sis), .sample_data(sd), .shunt_active(sh_act), .rail_active(rl_act),
    .continuous_mode(cont), .current_scale(scale), .span_select_out(span_o),
    .results_updated(upd));
  pmr_host host_u (.mclk(mclk), .reg_rdata(rdata), .reg_addr(addr), .reg_wr(wr),
    .reg_wdata(wdata));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  function automatic int shift_of(input int c);
    return c == 0 ? 0 : (c < 4 ? 2 * c : c + 3);
  endfunction
  // rail average never reported below zero
  function automatic logic [15:0] avg_exp(input logic signed [31:0] s, input int c, input bit rl);
    logic signed [31:0] q;
    q = s >>> shift_of(c);
    if (rl && q < 0) q = 0;
    return q[15:0];
  endfunction
  task automatic smp(input logic shunt, input logic [15:0] v);
    sis = shunt;
    sd = v;
    sv = 1'b1;
    @(posedge mclk);
    #1;
  endtask
  task automatic give_verdict();
    $display("counts: %0d checks, %0d mismatches", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      give_verdict();
    end
  end
  initial begin
    logic signed [31:0] sum;
    logic early;
    int n;
    n = $urandom(32'hf16b);
    repeat (3) @(posedge mclk);
    #1 srst = 1'b0;
    for (int i = 0; i < 5; i++) begin
      host_u.rd(ra[i], r);
      chk(r, rv[i], "reset value");
    end
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      d = (i == 0) ? 16'hffff : 16'($urandom);
      span = d[1];
      host_u.wr(4'h2, d);
      host_u.rd(4'h2, r);
      chk(r, {1'b0, d[14:0]}, "scale read");
      chk({1'b0, scale}, {1'b0, d[14:0]}, "scale out");
      chk({15'h0, span_o}, {15'h0, span}, "span");
    end
    $display("test scale done");
    for (int m = 0; m < 2; m++) begin
      for (int c = 0; c < 8; c++) begin
        host_u.wr(4'h1, (m[0] ? 16'h9000 : 16'ha000) | 16'(c));
        chk({13'h0, sh_act, rl_act, cont}, m[0] ? 16'h3 : 16'h5, "mode");
        n = 1 << shift_of(c);
        sum = 0;
        early = 1'b0;
        for (int i = 0; i < n; i++) begin
          // a sample of the idle input must not count
          if (i == n / 2) smp(m[0], 16'h7fff);
          d = 16'($urandom);
          sum = sum + $signed(d);
          smp(~m[0], d);
          early = early | ((i < n - 1) && upd);
        end
        sv = 1'b0;
        chk({15'h0, early}, 16'h0, "early update");
        chk({15'h0, upd}, 16'h1, "update pulse");
        e = avg_exp(sum, c, m[0]);
        host_u.wr(m[0] ? 4'h5 : 4'h4, ~e);
        host_u.rd(m[0] ? 4'h5 : 4'h4, r);
        chk(r, e, "average");
      end
    end
    $display("test averaging done");
    // reset in the middle of a rail run must drop the partial sum
    repeat (3) smp(1'b0, 16'h1234);
    sv = 1'b0;
    srst = 1'b1;
    @(posedge mclk);
    #1 srst = 1'b0;
    for (int i = 0; i < 5; i++) begin
      host_u.rd(ra[i], r);
      chk(r, rv[i], "mid-run reset");
    end
    smp(1'b0, 16'h0100);
    sv = 1'b0;
    host_u.rd(PMR_ADDR_RAIL, r);
    chk(r, 16'h0100, "rail after reset");
    $display("test reset in run done");
    // enable low freezes registers, runs and the update pulse
    ce_in = 1'b0;
    host_u.wr(PMR_ADDR_SCALE, 16'h0123);
    smp(1'b1, 16'h5555);
    sv = 1'b0;
    chk({15'h0, upd}, 16'h0, "frozen update");
    host_u.rd(PMR_ADDR_SCALE, r);
    chk(r, {1'b0, PMR_SCALE_RST}, "frozen scale");
    host_u.rd(PMR_ADDR_SHUNT, r);
    chk(r, PMR_RESULT_RST, "frozen shunt");
    ce_in = 1'b1;
    smp(1'b1, 16'h5555);
    sv = 1'b0;
    host_u.rd(PMR_ADDR_SHUNT, r);
    chk(r, 16'h5555, "shunt after freeze");
    $display("test clock enable done");
    give_verdict();
  end
endmodule
`default_nettype wire
